// [design/branch_and_bit_set_exec.sv]
// Execution of the relative jump and single-bit force instructions
`timescale 1ns/1ps
`default_nettype none
`include "branch_bit_defs.svh"
module branch_and_bit_set_exec
  import branch_bit_pkg::*;
#(
  parameter int PC_W = 21
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            instrValid,
  input  wire logic [15:0]     instrWord,
  input  wire logic [PC_W-1:0] pcIncremented,
  input  wire logic [3:0]      bankChoice,
  input  wire logic            extendedSetEn,
  input  wire logic [11:0]     indexBase,
  input  wire logic [7:0]      readData,
  output logic [1:0]           phase,
  output logic                 busy,
  output logic                 pcLoad,
  output logic [PC_W-1:0]      pcTarget,
  output logic                 memRead,
  output logic                 memWrite,
  output logic [11:0]          memAddr,
  output logic [7:0]           writeData,
  output logic                 statusWrite
);
  // Phase and sequencing state
  phase_t          phaseReg;
  phase_t          phaseNext;
  exec_t           stateReg;
  exec_t           stateNext;

  // Bit-force operands held from decode to write-back
  logic            forceActiveReg;
  logic            forceActiveNext;
  logic [11:0]     addrReg;
  logic [11:0]     addrNext;
  logic [2:0]      bitReg;
  logic [2:0]      bitNext;
  logic [7:0]      dataReg;
  logic [7:0]      dataNext;

  // Jump destination, held until the next jump
  logic [PC_W-1:0] targetReg;
  logic [PC_W-1:0] targetNext;

  function automatic logic [PC_W-1:0] jumpTarget(input logic [PC_W-1:0] pc,
                                                 input logic [`OFS_HI:0] n);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-`OFS_HI-1){n[`OFS_HI]}}, n};
    return pc + (ext << 1);
  endfunction

  // Next phase walks the Gray ring Q1, Q2, Q3, Q4
  function automatic phase_t phaseAfter(input phase_t p);
    phase_t q;
    case (p)
      Q1:      q = Q2;
      Q2:      q = Q3;
      Q3:      q = Q4;
      default: q = Q1;
    endcase
    return q;
  endfunction

  // Read-modify-write keeps the other seven bits as read
  function automatic logic [7:0] bitForce(input logic [7:0] value,
                                          input logic [2:0] pos);
    logic [7:0] mask;
    mask = 8'h01 << pos;
    return value | mask;
  endfunction

  // Phase and state decode
  wire atQ1    = (phaseReg == Q1);
  wire atQ2    = (phaseReg == Q2);
  wire atQ4    = (phaseReg == Q4);
  wire idle    = (stateReg == EXEC_IDLE);
  wire inJump  = (stateReg == EXEC_JUMP);
  wire inFlush = (stateReg == EXEC_FLUSH);

  // Opcode decode; other opcodes belong to other execution units
  wire [4:0] jumpField  = instrWord[`JUMP_OPC_HI:`JUMP_OPC_LO];
  wire [3:0] forceField = instrWord[`FORCE_OPC_HI:`FORCE_OPC_LO];
  wire       isJump     = (jumpField == `JUMP_OPC);
  wire       isForce    = (forceField == `FORCE_OPC);
  wire       take       = instrValid && atQ1 && idle;
  wire       takeJump   = take && isJump;
  wire       takeForce  = take && isForce;

  // Operand fields
  wire [`OFS_HI:0] jumpOffset = instrWord[`OFS_HI:0];
  wire [2:0]       bitIndex   = instrWord[`BIT_HI:`BIT_LO];
  wire             accessFlag = instrWord[`ACC_BIT];
  wire [7:0]       fileAddr   = instrWord[`FILE_HI:0];

  // Data address selection
  wire        inIndexWindow = (fileAddr <= `INDEX_LIMIT);
  wire        indexed       = !accessFlag && extendedSetEn && inIndexWindow;
  // Access bank splits: low part in bank 0, upper part in the top bank
  wire        upperAccess   = (fileAddr >= `ACC_HIGH_LIM);
  wire [3:0]  accessBank    = upperAccess ? `HIGH_BANK : `ACCESS_BANK;
  wire [3:0]  directBank    = accessFlag ? bankChoice : accessBank;
  wire [11:0] directAddr    = {directBank, fileAddr};
  // Indexed sum wraps inside the 12-bit data space
  wire [11:0] indexedAddr   = indexBase + {4'h0, fileAddr};
  wire [11:0] forceAddr     = indexed ? indexedAddr : directAddr;

  // Instruction-cycle boundaries and memory strobes
  wire jumpWriteback = inJump && atQ4;
  wire flushDone     = inFlush && atQ4;
  wire readPhase     = forceActiveReg && atQ2;
  wire writePhase    = forceActiveReg && atQ4;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      EXEC_IDLE: begin
        if (takeJump) begin
          stateNext = EXEC_JUMP;
        end
      end
      EXEC_JUMP: begin
        if (jumpWriteback) begin
          stateNext = EXEC_FLUSH;
        end
      end
      // Second cycle does nothing but hold off the next decode
      EXEC_FLUSH: begin
        if (flushDone) begin
          stateNext = EXEC_IDLE;
        end
      end
      default: begin
        stateNext = EXEC_IDLE;
      end
    endcase
  end

  // Next values of the datapath registers
  assign phaseNext       = phaseAfter(phaseReg);
  assign targetNext      = takeJump ? jumpTarget(pcIncremented, jumpOffset) : targetReg;
  assign forceActiveNext = takeForce ? 1'b1 : (atQ4 ? 1'b0 : forceActiveReg);
  assign addrNext        = takeForce ? forceAddr : addrReg;
  assign bitNext         = takeForce ? bitIndex : bitReg;
  // Read and modified in Q2, held through Q3, written back in Q4
  assign dataNext        = readPhase ? bitForce(readData, bitReg) : dataReg;

  // Sequencing registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phaseReg <= Q1;
    end else begin
      phaseReg <= phaseNext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg <= EXEC_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Datapath registers load only at decode or in their own phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      targetReg <= '0;
    end else begin
      targetReg <= targetNext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      forceActiveReg <= 1'b0;
    end else begin
      forceActiveReg <= forceActiveNext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addrReg <= 12'h000;
    end else begin
      addrReg <= addrNext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bitReg <= 3'h0;
    end else begin
      bitReg <= bitNext;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dataReg <= 8'h00;
    end else begin
      dataReg <= dataNext;
    end
  end

  // Busy covers the flush cycle too, so a request there is dropped
  assign phase       = phaseReg;
  assign busy        = !idle || forceActiveReg;
  assign pcLoad      = jumpWriteback;
  assign pcTarget    = targetReg;
  assign memRead     = readPhase;
  assign memWrite    = writePhase;
  assign memAddr     = addrReg;
  assign writeData   = dataReg;
  // Neither instruction touches flags
  assign statusWrite = 1'b0;
endmodule
`default_nettype wire

// [design/branch_bit_defs.svh]
// Constants for the relative jump and bit-force execution block
`ifndef BRANCH_BIT_DEFS_SVH
`define BRANCH_BIT_DEFS_SVH
`define JUMP_OPC       5'h1a
`define JUMP_OPC_HI    15
`define JUMP_OPC_LO    11
`define FORCE_OPC      4'h8
`define FORCE_OPC_HI   15
`define FORCE_OPC_LO   12
`define OFS_HI         10
`define BIT_HI         11
`define BIT_LO         9
`define ACC_BIT        8
`define FILE_HI        7
`define INDEX_LIMIT    8'h5f
`define ACCESS_BANK    4'h0
`define ACC_HIGH_LIM   8'h60
`define HIGH_BANK      4'hf
`define PC_STEP        21'h000002
`endif

// [design/branch_bit_pkg.sv]
// Types for the relative jump and bit-force execution block
package branch_bit_pkg;
  typedef enum logic [1:0] {
    Q1 = 2'h0,
    Q2 = 2'h1,
    Q3 = 2'h3,
    Q4 = 2'h2
  } phase_t;
  typedef enum logic [1:0] {
    EXEC_IDLE  = 2'h0,
    EXEC_JUMP  = 2'h1,
    EXEC_FLUSH = 2'h3
  } exec_t;
endpackage

// [test/branch_bit_monitor.sv]
// Checker for the relative jump and bit-force block
`timescale 1ns/1ps
`default_nettype none
module branch_bit_monitor
  import branch_bit_pkg::*;
#(parameter int PC_W = 21) (
  input wire logic            mclk,
  input wire logic            rst,
  input wire logic            instrValid,
  input wire logic            extendedSetEn,
  input wire logic            busy,
  input wire logic            pcLoad,
  input wire logic            memRead,
  input wire logic            memWrite,
  input wire logic            statusWrite,
  input wire logic [15:0]     instrWord,
  input wire logic [PC_W-1:0] pcIncremented,
  input wire logic [PC_W-1:0] pcTarget,
  input wire logic [3:0]      bankChoice,
  input wire logic [11:0]     indexBase,
  input wire logic [11:0]     memAddr,
  input wire logic [7:0]      readData,
  input wire logic [7:0]      writeData,
  input wire logic [1:0]      phase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = phase == 2'h0 && instrValid && !busy;
  wire jmp = take && instrWord[15:11] == 5'h1a;
  wire frc = take && instrWord[15:12] == 4'h8;
  wire [7:0] f = instrWord[7:0];
  wire idx = !instrWord[8] && extendedSetEn && f <= 8'h5f;
  sequence forceSteps; memRead ##1 !memRead && !memWrite ##1 memWrite; endsequence
  chk_jump_target: assert property (jmp |-> ##3 pcLoad && pcTarget ==
    $past(pcIncremented, 3) + {{(PC_W-12){$past(instrWord[10], 3)}}, $past(instrWord[10:0], 3),
    1'b0}) else $error("jump target wrong");
  chk_jump_busy: assert property (jmp |=> busy[*7] ##1 !busy)
    else $error("jump length wrong");
  chk_flush_idle: assert property (jmp |-> ##4 (!pcLoad && !memRead && !memWrite)[*4])
    else $error("flush cycle not idle");
  chk_status_quiet: assert property (!statusWrite) else $error("status written");
  chk_force_steps: assert property (frc |=> forceSteps) else $error("force strobes wrong");
  chk_force_data: assert property (frc |-> ##3 writeData ==
    ($past(readData, 2) | (8'h01 << $past(instrWord[11:9], 3)))) else $error("force data wrong");
  chk_bank_main: assert property (frc && instrWord[8] |=>
    memAddr == {$past(bankChoice), $past(f)}) else $error("bank address wrong");
  chk_access_bank: assert property (frc && !instrWord[8] && !idx |=> memAddr ==
    {($past(f) < 8'h60) ? 4'h0 : 4'hf, $past(f)}) else $error("access address wrong");
  chk_indexed_mode: assert property (frc && idx |=>
    memAddr == $past(indexBase) + $past(f)) else $error("indexed address wrong");
endmodule
bind branch_and_bit_set_exec branch_bit_monitor #(.PC_W(PC_W)) u_branch_bit_monitor (.*);
`default_nettype wire

// [test/branch_and_bit_set_exec_test.sv]
// Self-checking bench for the relative jump and bit-force block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((e) !== (g)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module branch_and_bit_set_exec_test;
  import branch_bit_pkg::*;
  logic mclk = 0, rst = 1, iv = 0, ext = 0, pl, mr, mw, sw, busy;
  logic [15:0] w = 0, s = 16'h0036;
  logic [20:0] pc = 0, pt;
  logic [3:0] bk = 0;
  logic [11:0] ix = 0, ma;
  logic [7:0] rd = 0, wd;
  logic [1:0] ph;
  int fails = 0, checksDone = 0, e;
  always #12.5 mclk = ~mclk;
  branch_and_bit_set_exec u_branch_and_bit_set_exec (.mclk(mclk), .rst(rst), .instrValid(iv),
    .instrWord(w), .pcIncremented(pc), .bankChoice(bk), .extendedSetEn(ext), .indexBase(ix),
    .readData(rd), .phase(ph), .busy(busy), .pcLoad(pl), .pcTarget(pt), .memRead(mr),
    .memWrite(mw), .memAddr(ma), .writeData(wd), .statusWrite(sw));
  function logic [15:0] nx(logic [15:0] v); return {v[14:0], v[15]^v[13]^v[12]^v[10]}; endfunction
  task step; @(posedge mclk); #1; endtask
  task close_out;
    $display("Checks %0d errors %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Longest instruction is eight cycles; allow nine per instruction and double it for margin
  initial begin #(60 * 9 * 25 * 2 + 1000); fails++; close_out; end
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst = 0;
    do step; while (ph !== 2'h0);
    for (int k = 0; k < 60; k++) begin
      s = nx(s); pc = {s[4:0], s}; s = nx(s); {bk, ix} = s; s = nx(s); {ext, rd} = s[8:0];
      s = nx(s); w = s[0] ? {5'h1a, s[15:5]} : {4'h8, s[15:4]};
      // Offset extremes and the indexed-window edge first
      case (k) 0: w = 16'hd400; 1: w = 16'hd3ff; 2: w = 16'h805f; 3: w = 16'h8060; endcase
      iv = 1; step; iv = 0;
      `CHK("statusWrite", 1'b0, sw)
      `CHK("phase", 2'h1, ph)
      `CHK("busy", 1'b1, busy)
      if (w[14]) begin
        e = (int'(pc) + 2 * (int'(w[10:0]) - (w[10] ? 2048 : 0))) & 21'h1fffff;
        step; step; `CHK("pcLoad", 1'b1, pl)
        `CHK("pcTarget", e, pt)
        iv = 1; w = 16'h8000; step; step; `CHK("memRead", 1'b0, mr)
        iv = 0; repeat (3) step;
        `CHK("busy", 1'b0, busy)
      end else begin
        e = w[8] ? bk * 256 + w[7:0] : (ext && w[7:0] <= 95) ? (ix + w[7:0]) % 4096
          : w[7:0] + (w[7:0] < 96 ? 0 : 3840);
        `CHK("memRead", 1'b1, mr)
        `CHK("memAddr", e, ma)
        step; `CHK("writeData", rd | (1 << w[11:9]), wd)
        step; `CHK("memWrite", 1'b1, mw)
        step;
        `CHK("busy", 1'b0, busy)
      end
    end
    close_out;
  end
endmodule
`default_nettype wire
